// [core/stec_regs.sv]
module stec_regs
  import stec_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic aeAutoEn,
  input wire logic aeFastEn,
  input wire logic [7:0] lumMeasured,
  input wire logic lumValid,
  input wire logic [2:0] overrideEn,
  output logic [11:0] extraHblankCount,
  output logic [15:0] vsyncWidthLines,
  output logic [10:0] hsyncStartPix,
  output logic [10:0] hsyncEndPix,
  output logic [2:0] pclkDivRatio,
  output logic [2:0] hwinEndLsbs,
  output logic [2:0] hwinStartLsbs,
  output logic [9:0] gainValue,
  output logic [15:0] exposureValue,
  output logic [15:0] vblankLines,
  output logic [9:0] zoomVstart,
  output logic [10:0] outHsize,
  output logic outHsizeValid,
  output logic [9:0] outVsize,
  output logic outVsizeValid,
  output logic denoiseEn,
  output logic [6:0] denoiseThreshold
);
  // Register store indexed by 7-bit address; unmapped entries keep their reset zero
  logic [7:0] regs_r [0:127];
  logic [7:0] regs_nxt [0:127];
  logic [7:0] rdata_r, rdata_nxt;
  logic [9:0] gainLow_r, gainLow_nxt;
  logic [9:0] expLow_r, expLow_nxt;
  logic [7:0] gainHigh;
  stec_ae_dir_t aeDir;
  logic [3:0] aeStep;

  function automatic logic isMapped(input logic [7:0] a);
    case (a)
      ADDR_LUM_HIGH_THRESHOLD, ADDR_LUM_LOW_THRESHOLD, ADDR_FAST_STEP_THRESHOLDS,
      ADDR_HSYNC_ADJUST_HBLANK_HIGH, ADDR_EXTRA_HBLANK_LOW, ADDR_VSYNC_EXTEND_LOW,
      ADDR_VSYNC_EXTEND_HIGH, ADDR_LUMINANCE_AVERAGE, ADDR_HSYNC_START_LOW,
      ADDR_HSYNC_END_LOW, ADDR_CLKDIV_HWINDOW_LOW, ADDR_GAIN_EXPOSURE_HIGH,
      ADDR_VBLANK_LINES_LOW, ADDR_VBLANK_LINES_HIGH, ADDR_ZOOM_VSTART_LOW,
      ADDR_ZOOM_VSTART_HIGH, ADDR_OUTPUT_SIZE_HIGH_BITS, ADDR_OUTPUT_HSIZE_LOW,
      ADDR_OUTPUT_VSIZE_LOW, ADDR_DENOISE_CONTROL: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] resetOf(input logic [7:0] a);
    case (a)
      ADDR_LUM_HIGH_THRESHOLD: resetOf = RST_LUM_HIGH_THRESHOLD;
      ADDR_LUM_LOW_THRESHOLD: resetOf = RST_LUM_LOW_THRESHOLD;
      ADDR_FAST_STEP_THRESHOLDS: resetOf = RST_FAST_STEP_THRESHOLDS;
      ADDR_HSYNC_START_LOW: resetOf = RST_HSYNC_START_LOW;
      ADDR_HSYNC_END_LOW: resetOf = RST_HSYNC_END_LOW;
      default: resetOf = RST_ZERO;
    endcase
  endfunction

  // Gain/exposure direction from luminance vs thresholds
  always_comb begin
    aeDir = STEC_AE_HOLD;
    aeStep = AE_STEP_SMALL;
    if (aeAutoEn && lumValid) begin
      if (lumMeasured > regs_r[ADDR_LUM_HIGH_THRESHOLD[6:0]]) begin
        aeDir = STEC_AE_DOWN;
      end else if (lumMeasured < regs_r[ADDR_LUM_LOW_THRESHOLD[6:0]]) begin
        aeDir = STEC_AE_UP;
      end
      // Nibble thresholds compared against the luminance high nibble
      if (aeFastEn && (lumMeasured[7:4] > regs_r[ADDR_FAST_STEP_THRESHOLDS[6:0]][7:4] ||
          lumMeasured[7:4] < regs_r[ADDR_FAST_STEP_THRESHOLDS[6:0]][3:0])) begin
        aeStep = AE_STEP_LARGE;
      end
    end
  end

  // Register writes, luminance refresh and gain/exposure stepping
  always_comb begin
    logic [7:0] ge;
    logic [15:0] gainFull;
    logic [15:0] expFull;
    ge = 8'h00;
    gainFull = 16'h0000;
    expFull = 16'h0000;
    for (int i = 0; i < 128; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    gainLow_nxt = gainLow_r;
    expLow_nxt = expLow_r;
    // Host write ignored at unmapped addresses
    if (regWr && isMapped(regAddr)) begin
      regs_nxt[regAddr[6:0]] = regWdata;
    end
    // Hardware refresh wins over a host write in the same cycle
    if (lumValid) begin
      regs_nxt[ADDR_LUMINANCE_AVERAGE[6:0]] = lumMeasured;
    end
    ge = regs_r[ADDR_GAIN_EXPOSURE_HIGH[6:0]];
    gainFull = {6'h00, ge[7:6], gainLow_r[7:0]};
    expFull = {ge[5:0], expLow_r};
    if (aeDir == STEC_AE_UP) begin
      gainFull = (gainFull + {12'h000, aeStep} > 16'h03ff) ? 16'h03ff
               : gainFull + {12'h000, aeStep};
      expFull = (expFull > 16'hffff - {12'h000, aeStep}) ? 16'hffff
              : expFull + {12'h000, aeStep};
    end else if (aeDir == STEC_AE_DOWN) begin
      gainFull = (gainFull < {12'h000, aeStep}) ? 16'h0000 : gainFull - {12'h000, aeStep};
      expFull = (expFull < {12'h000, aeStep}) ? 16'h0000 : expFull - {12'h000, aeStep};
    end
    if (aeDir != STEC_AE_HOLD) begin
      regs_nxt[ADDR_GAIN_EXPOSURE_HIGH[6:0]] = {gainFull[9:8], expFull[15:10]};
      gainLow_nxt = {2'b00, gainFull[7:0]};
      expLow_nxt = expFull[9:0];
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (regRd && isMapped(regAddr)) begin
      rdata_nxt = regs_r[regAddr[6:0]];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 128; g++) begin : gen_reg
      always_ff @(posedge clk) begin
        if (srst) begin
          regs_r[g] <= resetOf(8'(g));
        end else begin
          regs_r[g] <= regs_nxt[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r <= 8'h00;
      gainLow_r <= 10'h000;
      expLow_r <= 10'h000;
    end else begin
      rdata_r <= rdata_nxt;
      gainLow_r <= gainLow_nxt;
      expLow_r <= expLow_nxt;
    end
  end

  assign regRdata = rdata_r;
  assign gainHigh = regs_r[ADDR_GAIN_EXPOSURE_HIGH[6:0]];

  // Derived timing fields, decoded from flops; the valids and hblank gate use overrideEn
  always_comb begin
    logic [7:0] adj;
    logic [7:0] sz;
    logic [1:0] div;
    adj = regs_r[ADDR_HSYNC_ADJUST_HBLANK_HIGH[6:0]];
    sz = regs_r[ADDR_OUTPUT_SIZE_HIGH_BITS[6:0]];
    div = regs_r[ADDR_CLKDIV_HWINDOW_LOW[6:0]][7:6];
    // Zero when the enable is clear, so timing sees no stale count
    extraHblankCount = overrideEn[1] ? {adj[7:4], regs_r[ADDR_EXTRA_HBLANK_LOW[6:0]]}
                                     : 12'h000;
    vsyncWidthLines = VSYNC_BASE_LINES + {regs_r[ADDR_VSYNC_EXTEND_HIGH[6:0]],
                      regs_r[ADDR_VSYNC_EXTEND_LOW[6:0]]};
    // Pixel units: count times two
    hsyncStartPix = {adj[1:0], regs_r[ADDR_HSYNC_START_LOW[6:0]], 1'b0};
    hsyncEndPix = {adj[3:2], regs_r[ADDR_HSYNC_END_LOW[6:0]], 1'b0};
    case (div)
      2'b10: pclkDivRatio = 3'd2;
      2'b11: pclkDivRatio = 3'd4;
      default: pclkDivRatio = 3'd1;
    endcase
    hwinEndLsbs = regs_r[ADDR_CLKDIV_HWINDOW_LOW[6:0]][5:3];
    hwinStartLsbs = regs_r[ADDR_CLKDIV_HWINDOW_LOW[6:0]][2:0];
    gainValue = {gainHigh[7:6], gainLow_r[7:0]};
    exposureValue = {gainHigh[5:0], expLow_r};
    vblankLines = {regs_r[ADDR_VBLANK_LINES_HIGH[6:0]],
                   regs_r[ADDR_VBLANK_LINES_LOW[6:0]]};
    zoomVstart = {regs_r[ADDR_ZOOM_VSTART_HIGH[6:0]],
                  regs_r[ADDR_ZOOM_VSTART_LOW[6:0]][1:0]};
    outHsize = {sz[2:0], regs_r[ADDR_OUTPUT_HSIZE_LOW[6:0]]};
    outHsizeValid = overrideEn[0];
    outVsize = {sz[5:4], regs_r[ADDR_OUTPUT_VSIZE_LOW[6:0]]};
    outVsizeValid = overrideEn[2];
    denoiseEn = regs_r[ADDR_DENOISE_CONTROL[6:0]][6];
    denoiseThreshold = regs_r[ADDR_DENOISE_CONTROL[6:0]][5]
                     ? {regs_r[ADDR_DENOISE_CONTROL[6:0]][4:0], 2'b00}
                     : {2'b00, regs_r[ADDR_DENOISE_CONTROL[6:0]][4:0]};
  end

  a_ae_down: assert property (@(posedge clk) disable iff (srst)
    aeAutoEn && lumValid && lumMeasured > regs_r[ADDR_LUM_HIGH_THRESHOLD[6:0]]
    && (gainValue != 10'h000) |=> gainValue < $past(gainValue))
    else $error("gain did not drop above high threshold");

  a_ae_up: assert property (@(posedge clk) disable iff (srst)
    aeAutoEn && lumValid && lumMeasured < regs_r[ADDR_LUM_LOW_THRESHOLD[6:0]]
    && lumMeasured <= regs_r[ADDR_LUM_HIGH_THRESHOLD[6:0]]
    && (gainValue != 10'h3ff) |=> gainValue > $past(gainValue))
    else $error("gain did not rise below low threshold");

  a_fast_step: assert property (@(posedge clk) disable iff (srst)
    !aeFastEn |-> aeStep == AE_STEP_SMALL)
    else $error("large step outside fast mode");

  a_step_large: assert property (@(posedge clk) disable iff (srst)
    aeAutoEn && lumValid && aeFastEn
    && lumMeasured[7:4] > regs_r[ADDR_FAST_STEP_THRESHOLDS[6:0]][7:4]
    |-> aeStep == AE_STEP_LARGE)
    else $error("no large step above fast threshold");

  a_lum_refresh: assert property (@(posedge clk) disable iff (srst)
    lumValid |=> regs_r[ADDR_LUMINANCE_AVERAGE[6:0]] == $past(lumMeasured))
    else $error("luminance average not refreshed");

  a_hblank_gate: assert property (@(posedge clk) disable iff (srst)
    !overrideEn[1] |-> extraHblankCount == 12'h000)
    else $error("extra hblank applied while disabled");

  a_hblank_low: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_EXTRA_HBLANK_LOW && overrideEn[1]
    |=> !overrideEn[1] || extraHblankCount[7:0] == $past(regWdata))
    else $error("extra hblank low byte not applied");

  a_reserved_ignore: assert property (@(posedge clk) disable iff (srst)
    regWr && !isMapped(regAddr) ##1 regRd && regAddr == $past(regAddr)
    |=> regRdata == 8'h00)
    else $error("reserved address took a write");

  a_write_read: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_DENOISE_CONTROL ##1 regRd && regAddr == ADDR_DENOISE_CONTROL
    |=> regRdata == $past(regWdata, 2))
    else $error("de-noise readback mismatch");

  a_pclk_div: assert property (@(posedge clk) disable iff (srst)
    regs_r[ADDR_CLKDIV_HWINDOW_LOW[6:0]][7] == 1'b0 |-> pclkDivRatio == 3'd1)
    else $error("clock divided for no-effect code");

  a_pclk_half: assert property (@(posedge clk) disable iff (srst)
    regs_r[ADDR_CLKDIV_HWINDOW_LOW[6:0]][7:6] == 2'b10 |-> pclkDivRatio == 3'd2)
    else $error("clock not halved");

  a_pclk_quarter: assert property (@(posedge clk) disable iff (srst)
    regs_r[ADDR_CLKDIV_HWINDOW_LOW[6:0]][7:6] == 2'b11 |-> pclkDivRatio == 3'd4)
    else $error("clock not divided by four");

  a_vsync_low: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_VSYNC_EXTEND_LOW
    |=> vsyncWidthLines == VSYNC_BASE_LINES
        + {regs_r[ADDR_VSYNC_EXTEND_HIGH[6:0]], $past(regWdata)})
    else $error("vsync low extension wrong");

  a_vsync_high: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_VSYNC_EXTEND_HIGH
    |=> vsyncWidthLines == VSYNC_BASE_LINES
        + {$past(regWdata), regs_r[ADDR_VSYNC_EXTEND_LOW[6:0]]})
    else $error("vsync high extension wrong");

  a_hsync_start: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_HSYNC_START_LOW
    |=> hsyncStartPix[8:1] == $past(regWdata) && hsyncStartPix[0] == 1'b0)
    else $error("hsync start low byte wrong");

  a_hsync_end: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_HSYNC_END_LOW
    |=> hsyncEndPix[8:1] == $past(regWdata) && hsyncEndPix[0] == 1'b0)
    else $error("hsync end low byte wrong");

  a_hsync_msbs: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_HSYNC_ADJUST_HBLANK_HIGH
    |=> hsyncStartPix[10:9] == $past(regWdata[1:0])
        && hsyncEndPix[10:9] == $past(regWdata[3:2]))
    else $error("hsync high bits wrong");

  a_window_lsbs: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_CLKDIV_HWINDOW_LOW
    |=> {hwinEndLsbs, hwinStartLsbs} == $past(regWdata[5:0]))
    else $error("window low bits wrong");

  a_gain_high: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_GAIN_EXPOSURE_HIGH && aeDir == STEC_AE_HOLD
    |=> gainValue[9:8] == $past(regWdata[7:6])
        && exposureValue[15:10] == $past(regWdata[5:0]))
    else $error("gain or exposure high bits wrong");

  a_vblank_low: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_VBLANK_LINES_LOW |=> vblankLines[7:0] == $past(regWdata))
    else $error("vblank low byte wrong");

  a_vblank_high: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_VBLANK_LINES_HIGH |=> vblankLines[15:8] == $past(regWdata))
    else $error("vblank high byte wrong");

  a_zoom_low: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_ZOOM_VSTART_LOW |=> zoomVstart[1:0] == $past(regWdata[1:0]))
    else $error("zoom start low bits wrong");

  a_zoom_high: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_ZOOM_VSTART_HIGH |=> zoomVstart[9:2] == $past(regWdata))
    else $error("zoom start high byte wrong");

  a_hsize_low: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_OUTPUT_HSIZE_LOW |=> outHsize[7:0] == $past(regWdata))
    else $error("horizontal size low byte wrong");

  a_vsize_low: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_OUTPUT_VSIZE_LOW |=> outVsize[7:0] == $past(regWdata))
    else $error("vertical size low byte wrong");

  a_size_msbs: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_OUTPUT_SIZE_HIGH_BITS
    |=> outHsize[10:8] == $past(regWdata[2:0]) && outVsize[9:8] == $past(regWdata[5:4]))
    else $error("output size high bits wrong");

  a_denoise_scale: assert property (@(posedge clk) disable iff (srst)
    regWr && regAddr == ADDR_DENOISE_CONTROL && regWdata[5]
    |=> denoiseThreshold == {$past(regWdata[4:0]), 2'b00})
    else $error("de-noise threshold not scaled");

  c_ae_down: cover property (@(posedge clk) aeDir == STEC_AE_DOWN);
  c_reserved_wr: cover property (@(posedge clk) regWr && !isMapped(regAddr));
  c_hblank_on: cover property (@(posedge clk) overrideEn[1] && extraHblankCount != 12'h000);
  c_ae_up_fast: cover property (@(posedge clk) aeDir == STEC_AE_UP && aeStep == AE_STEP_LARGE);
  c_wr_rd: cover property (@(posedge clk) regWr ##1 regRd);
endmodule

// [core/stec_pkg.sv]
package stec_pkg;
  localparam logic [7:0] ADDR_LUM_HIGH_THRESHOLD = 8'h24;
  localparam logic [7:0] ADDR_LUM_LOW_THRESHOLD = 8'h25;
  localparam logic [7:0] ADDR_FAST_STEP_THRESHOLDS = 8'h26;
  localparam logic [7:0] ADDR_HSYNC_ADJUST_HBLANK_HIGH = 8'h2a;
  localparam logic [7:0] ADDR_EXTRA_HBLANK_LOW = 8'h2b;
  localparam logic [7:0] ADDR_VSYNC_EXTEND_LOW = 8'h2d;
  localparam logic [7:0] ADDR_VSYNC_EXTEND_HIGH = 8'h2e;
  localparam logic [7:0] ADDR_LUMINANCE_AVERAGE = 8'h2f;
  localparam logic [7:0] ADDR_HSYNC_START_LOW = 8'h30;
  localparam logic [7:0] ADDR_HSYNC_END_LOW = 8'h31;
  localparam logic [7:0] ADDR_CLKDIV_HWINDOW_LOW = 8'h32;
  localparam logic [7:0] ADDR_GAIN_EXPOSURE_HIGH = 8'h45;
  localparam logic [7:0] ADDR_VBLANK_LINES_LOW = 8'h46;
  localparam logic [7:0] ADDR_VBLANK_LINES_HIGH = 8'h47;
  localparam logic [7:0] ADDR_ZOOM_VSTART_LOW = 8'h48;
  localparam logic [7:0] ADDR_ZOOM_VSTART_HIGH = 8'h49;
  localparam logic [7:0] ADDR_OUTPUT_SIZE_HIGH_BITS = 8'h5f;
  localparam logic [7:0] ADDR_OUTPUT_HSIZE_LOW = 8'h60;
  localparam logic [7:0] ADDR_OUTPUT_VSIZE_LOW = 8'h61;
  localparam logic [7:0] ADDR_DENOISE_CONTROL = 8'h63;

  localparam logic [7:0] RST_LUM_HIGH_THRESHOLD = 8'h78;
  localparam logic [7:0] RST_LUM_LOW_THRESHOLD = 8'h68;
  localparam logic [7:0] RST_FAST_STEP_THRESHOLDS = 8'hd4;
  localparam logic [7:0] RST_HSYNC_START_LOW = 8'h08;
  localparam logic [7:0] RST_HSYNC_END_LOW = 8'h30;
  localparam logic [7:0] RST_ZERO = 8'h00;

  localparam logic [15:0] VSYNC_BASE_LINES = 16'h0004;
  localparam logic [3:0] AE_STEP_SMALL = 4'h1;
  localparam logic [3:0] AE_STEP_LARGE = 4'h8;

  typedef enum logic [1:0] {
    STEC_AE_HOLD = 2'b00,
    STEC_AE_UP = 2'b01,
    STEC_AE_DOWN = 2'b10
  } stec_ae_dir_t;
endpackage

// [verif/stec_host.sv]
module stec_host (
  input wire logic clk,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  output logic regWr,
  output logic regRd,
  input wire logic [7:0] regRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // Idle lines show the inverse, so a stale address never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask
  // Write then read with no gap, as the bus allows
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] w, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= w;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~w;
    #1;
    d = regRdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdata;
  endtask
endmodule

// [verif/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] regAddr, regWdata, regRdata, lumMeasured = 8'h00, d;
  logic regWr, regRd, aeAutoEn = 1'b0, aeFastEn = 1'b0, lumValid = 1'b0;
  logic [2:0] overrideEn = 3'b010;
  logic [11:0] extraHblankCount;
  logic [15:0] vsyncWidthLines, exposureValue, vblankLines;
  logic [10:0] hsyncStartPix, hsyncEndPix, outHsize;
  logic [2:0] pclkDivRatio, hwinEndLsbs, hwinStartLsbs;
  logic [9:0] gainValue, zoomVstart, outVsize;
  logic outHsizeValid, outVsizeValid, denoiseEn;
  logic [6:0] denoiseThreshold;
  int bad_count = 0;
  int num_checks = 0;
  localparam logic [7:0] ADR [20] = '{8'h24, 8'h25, 8'h26, 8'h2a, 8'h2b, 8'h2d, 8'h2e, 8'h2f,
    8'h30, 8'h31, 8'h32, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h5f, 8'h60, 8'h61, 8'h63};
  localparam logic [7:0] RST [20] = '{8'h78, 8'h68, 8'hd4, 0, 0, 0, 0, 0, 8'h08, 8'h30,
    0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  localparam logic [7:0] LUM [8] = '{8'h90, 8'h50, 8'h70, 8'h10, 8'h10, 8'h50, 8'hf0, 8'h90};
  localparam logic [1:0] MD [8] = '{2'b10, 2'b10, 2'b10, 2'b00, 2'b11, 2'b11, 2'b11, 2'b11};
  localparam logic [9:0] GX [8] = '{10'h0, 10'h1, 10'h1, 10'h1, 10'h9, 10'ha, 10'h2, 10'h1};

  always #2.5 clk = ~clk;

  stec_regs i_stec_regs (.clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .aeAutoEn(aeAutoEn),
    .aeFastEn(aeFastEn), .lumMeasured(lumMeasured), .lumValid(lumValid),
    .overrideEn(overrideEn), .extraHblankCount(extraHblankCount),
    .vsyncWidthLines(vsyncWidthLines), .hsyncStartPix(hsyncStartPix),
    .hsyncEndPix(hsyncEndPix), .pclkDivRatio(pclkDivRatio), .hwinEndLsbs(hwinEndLsbs),
    .hwinStartLsbs(hwinStartLsbs), .gainValue(gainValue), .exposureValue(exposureValue),
    .vblankLines(vblankLines), .zoomVstart(zoomVstart), .outHsize(outHsize),
    .outHsizeValid(outHsizeValid), .outVsize(outVsize), .outVsizeValid(outVsizeValid),
    .denoiseEn(denoiseEn), .denoiseThreshold(denoiseThreshold));

  stec_host i_stec_host (.clk(clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard: well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      i_stec_host.rd(ADR[i], d);
      chk("reset value", RST[i], d);
    end
    i_stec_host.wr(8'h27, 8'hff);
    i_stec_host.rd(8'h27, d);
    chk("reserved 27", 0, d);
    i_stec_host.wr(8'h64, 8'h5a);
    i_stec_host.rd(8'h64, d);
    chk("reserved 64", 0, d);
    $display("reset and reserved test done");
    for (int i = 0; i < 20; i++) i_stec_host.wr(ADR[i], 8'ha5 ^ 8'(i));
    for (int i = 0; i < 20; i++) begin
      i_stec_host.rd(ADR[i], d);
      chk("readback", 8'ha5 ^ 8'(i), d);
    end
    $display("readback test done");
    i_stec_host.wr(8'h2a, 8'hb6);
    i_stec_host.wr(8'h2b, 8'hc3);
    i_stec_host.wr(8'h30, 8'h81);
    i_stec_host.wr(8'h31, 8'h7e);
    i_stec_host.wr(8'h2d, 8'h05);
    i_stec_host.wr(8'h2e, 8'h01);
    i_stec_host.wr(8'h46, 8'h34);
    i_stec_host.wr(8'h47, 8'h12);
    i_stec_host.wr(8'h48, 8'hfe);
    i_stec_host.wr(8'h49, 8'h9c);
    i_stec_host.wr(8'h5f, 8'hda);
    i_stec_host.wr(8'h60, 8'h33);
    i_stec_host.wr(8'h61, 8'h44);
    i_stec_host.wr(8'h63, 8'h55);
    i_stec_host.wr(8'h45, 8'hc0);
    #1;
    chk("hblank on", 16'h0bc3, extraHblankCount);
    chk("hsync start", 16'h0502, hsyncStartPix);
    chk("hsync end", 16'h02fc, hsyncEndPix);
    chk("vsync width", 16'h0109, vsyncWidthLines);
    chk("vblank", 16'h1234, vblankLines);
    chk("zoom start", 16'h0272, zoomVstart);
    chk("hsize", 16'h0233, outHsize);
    chk("vsize", 16'h0144, outVsize);
    chk("size valids off", 0, {outHsizeValid, outVsizeValid});
    chk("denoise x1", 16'h0095, {denoiseEn, denoiseThreshold});
    chk("gain high", 16'h0003, gainValue[9:8]);
    chk("exposure high", 0, exposureValue[15:10]);
    @(posedge clk);
    overrideEn <= 3'b101;
    i_stec_host.wr(8'h63, 8'h35);
    i_stec_host.wr(8'h45, 8'h2a);
    #1;
    chk("hblank off", 0, extraHblankCount);
    chk("size valids on", 16'h0003, {outHsizeValid, outVsizeValid});
    chk("denoise x4", 16'h0054, {denoiseEn, denoiseThreshold});
    chk("gain high 0", 0, gainValue[9:8]);
    chk("exposure high 2a", 16'h002a, exposureValue[15:10]);
    for (int c = 0; c < 4; c++) begin
      i_stec_host.wr(8'h32, {2'(c), 6'b101011});
      #1;
      chk("clock ratio", (c < 2) ? 16'h1 : ((c == 2) ? 16'h2 : 16'h4), pclkDivRatio);
      chk("window lsbs", 16'h002b, {hwinEndLsbs, hwinStartLsbs});
    end
    $display("field mapping test done");
    i_stec_host.wr(8'h24, 8'h78);
    i_stec_host.wr(8'h25, 8'h68);
    i_stec_host.wr(8'h26, 8'hd4);
    i_stec_host.wr(8'h45, 8'h00);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      aeAutoEn <= MD[i][1];
      aeFastEn <= MD[i][0];
      lumMeasured <= LUM[i];
      lumValid <= 1'b1;
      @(posedge clk);
      lumValid <= 1'b0;
      @(posedge clk);
      #1;
      chk("gain step", GX[i], gainValue);
      chk("exposure step", 16'(GX[i]), exposureValue);
      i_stec_host.rd(8'h2f, d);
      chk("luminance average", LUM[i], d);
    end
    $display("exposure loop test done");
    i_stec_host.wr_rd(8'h63, 8'h2c, d);
    chk("back to back denoise", 16'h002c, d);
    i_stec_host.wr_rd(8'h3a, 8'h77, d);
    chk("back to back reserved", 0, d);
    $display("back to back test done");
    summarize();
  end
endmodule
